// *** rtl/subaudio_pkg.sv ***
package subaudio_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int BIT_RATE_DHZ  = 1344;          // 134.4 in tenths
    localparam int BIT_CYC       = CLK_HZ * 10 / BIT_RATE_DHZ;
    localparam int TOFF_HALF_CYC = CLK_HZ * 10 / (2 * BIT_RATE_DHZ);
    localparam int TOFF_TOL_PCT  = 10;
    localparam int TOFF_HALVES   = 20;
    localparam int PH_DONE_MS    = 20;
    localparam int PH_HALF_STEPS = 128;
    localparam int PH_STEP_CYC   = CLK_HZ / 1000 * PH_DONE_MS / PH_HALF_STEPS;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0]  ADDR_SEL     = 8'hC2;
    localparam logic [7:0]  ADDR_STATUS  = 8'hC6;
    localparam logic [7:0]  ADDR_REPORT  = 8'hCC;
    localparam logic [15:0] SEL_RST      = 16'h0000;
    localparam int          ST_VALID_BIT = 10;
    localparam int          LEN24_BIT    = 11;
    localparam int          PH_LSB       = 8;

    ////////////////////////////////////////////////////////////////////////////
    // selector values
    localparam logic [7:0] SEL_TRUE_LO = 8'h01;
    localparam logic [7:0] SEL_USER    = 8'h54;    // 84
    localparam logic [7:0] SEL_INV_OFS = 8'h64;    // 100
    localparam logic [7:0] SEL_INV_LO  = 8'h65;    // 101
    localparam logic [7:0] SEL_INV_HI  = 8'hB8;    // 184
    localparam logic [7:0] SEL_TOFF    = 8'hFE;    // 254
    localparam logic [4:0] ERR_MAX     = 5'h03;
    localparam logic [1:0] EVAL_LAST   = 2'h3;     // every 4th bit
    localparam logic [4:0] LEN23       = 5'h17;
    localparam logic [4:0] LEN24       = 5'h18;

    ////////////////////////////////////////////////////////////////////////////
    // phase lag targets in 1/256 turn
    localparam logic [7:0] PH_0   = 8'h00;
    localparam logic [7:0] PH_120 = 8'h55;
    localparam logic [7:0] PH_180 = 8'h80;
    localparam logic [7:0] PH_240 = 8'hAB;

    typedef struct packed {
        logic code_bit;
        logic shift_pos;
    } tx_sym_s;

    typedef logic [22:0] code_t;

    // bits 22-12 in the top three digits, bits 11-0 in the low three
    localparam code_t CODE_TBL [1:83] = '{
        23'h763813, 23'h6B7815, 23'h65D816, 23'h51F819, 23'h5F581A, 23'h5B6823,
        23'h0FD827, 23'h7CA829, 23'h6F482C, 23'h5D1835, 23'h679839, 23'h69383A,
        23'h2E683B, 23'h74783C, 23'h35E84C, 23'h72B84D, 23'h7C184E, 23'h07B855,
        23'h3D3859, 23'h33985A, 23'h2ED85C, 23'h37A863, 23'h1EC86A, 23'h44D86D,
        23'h4A786E, 23'h6BC872, 23'h31D875, 23'h05F87A, 23'h18B87C, 23'h6E9885,
        23'h68E893, 23'h7B0896, 23'h45B8A3, 23'h1FA8A4, 23'h58F8A5, 23'h6278A9,
        23'h1778B1, 23'h5E88B3, 23'h43C8B5, 23'h7948B9, 23'h0CF8C6, 23'h38D8C9,
        23'h6C68CD, 23'h23E8D9, 23'h2978E3, 23'h3A98E6, 23'h0EB8E9, 23'h6858F4,
        23'h2F08F5, 23'h1588F9, 23'h776909, 23'h79C90A, 23'h3E990B, 23'h4B9913,
        23'h6C5919, 23'h62F91A, 23'h7B8925, 23'h27E934, 23'h60B935, 23'h6E1936,
        23'h3C6943, 23'h2F8946, 23'h41B94E, 23'h0E395A, 23'h19E966, 23'h0C7975,
        23'h5D9986, 23'h67198A, 23'h0F5994, 23'h01F997, 23'h728999, 23'h7C299A,
        23'h4C39AC, 23'h2479B2, 23'h3939B4, 23'h22B9C3, 23'h0BD9CA, 23'h3989D3,
        23'h1E49D9, 23'h10E9DA, 23'h0DA9DC, 23'h14D9E3, 23'h20F9EC
    };

endpackage

// *** rtl/tx_sym_buffer.sv ***
`timescale 1ns/1ps
module tx_sym_buffer #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // fill side
    input  wire logic             i_push_valid,
    input  wire logic [WIDTH-1:0] i_push_data,
    output logic                  o_push_ready,
    // drain side
    output logic                  o_pop_valid,
    output logic [WIDTH-1:0]      o_pop_data,
    input  wire logic             i_pop_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
        $error("buffer depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0]    cnt_r, cnt_nxt;
    logic             push, pop;

    assign o_push_ready = (cnt_r != CW'(DEPTH));
    assign o_pop_valid  = (cnt_r != '0);
    assign o_pop_data   = mem_r[rp_r];

    always_comb begin
        push    = i_push_valid && o_push_ready;
        pop     = o_pop_valid && i_pop_ready;
        wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = CW'(cnt_r + CW'(push) - CW'(pop));
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    for (genvar g = 0; g < DEPTH; g++) begin : g_mem
        always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
                mem_r[g] <= '0;
            end else if (push && wp_r == AW'(g)) begin
                mem_r[g] <= i_push_data;
            end
        end
    end

endmodule

// *** rtl/subaudio_digital_code_codec.sv ***
`timescale 1ns/1ps
module subaudio_digital_code_codec #(
    parameter int P_BIT_CYC       = subaudio_pkg::BIT_CYC,
    parameter int P_TOFF_HALF_CYC = subaudio_pkg::TOFF_HALF_CYC
) (
    // clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_arst_n,
    // host register port
    input  wire logic                  i_wr_en,
    input  wire logic                  i_rd_en,
    input  wire logic [7:0]            i_addr,
    input  wire logic [15:0]           i_wr_data,
    output logic [15:0]                o_rd_data,
    output logic                       o_rd_valid,
    // setup and mode
    input  wire logic [15:0]           i_setup_word,
    input  wire logic [23:0]           i_user_code,
    input  wire logic                  i_dcs_en,
    input  wire logic                  i_ctcss_en,
    input  wire logic                  i_tx_mode,
    // receive path
    input  wire logic                  i_rx_slice,
    output logic                       o_ctcss_det_en,
    output logic                       o_dcs_event,
    // transmit code stream
    output logic                       o_tx_valid,
    output subaudio_pkg::tx_sym_s      o_tx_sym,
    input  wire logic                  i_tx_ready,
    // transmit tone generator
    output logic [7:0]                 o_tone_sel,
    output logic [7:0]                 o_tone_lag,
    output logic                       o_toff_sq
);
    import subaudio_pkg::*;

    localparam int          CW       = 17;
    localparam logic [CW-1:0] BIT_LAST = CW'(P_BIT_CYC - 1);
    localparam logic [CW-1:0] BIT_MID  = CW'(P_BIT_CYC / 2);
    localparam logic [CW-1:0] TOFF_LO  = CW'(P_TOFF_HALF_CYC * (100 - TOFF_TOL_PCT) / 100);
    localparam logic [CW-1:0] TOFF_HI  = CW'(P_TOFF_HALF_CYC * (100 + TOFF_TOL_PCT) / 100);
    localparam logic [CW-1:0] TOFF_LAST = CW'(P_TOFF_HALF_CYC - 1);
    localparam logic [CW-1:0] CNT_MAX  = {CW{1'b1}};
    localparam logic [11:0]   PH_LAST  = 12'(PH_STEP_CYC - 1);
    localparam logic [4:0]    HALVES_LAST = 5'(TOFF_HALVES - 1);

    if (P_BIT_CYC < 8 || P_BIT_CYC >= 2**CW || P_TOFF_HALF_CYC < 8
        || P_TOFF_HALF_CYC * (100 + TOFF_TOL_PCT) / 100 >= 2**CW - 1) begin
        $error("bit or tone period out of counter range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchroniser
    logic       rst_meta_r, rst_n;
    logic [1:0] rx_sync_r;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync_r <= 2'b00;
        end else begin
            rx_sync_r <= {rx_sync_r[0], i_rx_slice};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // selector decode
    logic [15:0] sel_r, sel_nxt;
    logic [7:0]  sv;
    logic        code_ok, code_inv, len24;
    logic [6:0]  code_idx;
    logic [23:0] pat, mask;
    logic [4:0]  len;

    function automatic logic [4:0] ones(input logic [23:0] x);
        logic [4:0] n;
        n = '0;
        for (int i = 0; i < 24; i++) begin
            n = n + 5'(x[i]);
        end
        return n;
    endfunction

    always_comb begin
        sv       = sel_r[7:0];
        code_ok  = 1'b0;
        code_inv = 1'b0;
        code_idx = '0;
        if (sv >= SEL_TRUE_LO && sv <= SEL_USER) begin
            code_ok  = 1'b1;
            code_idx = sv[6:0];
        end else if (sv >= SEL_INV_LO && sv <= SEL_INV_HI) begin
            code_ok  = 1'b1;
            code_inv = 1'b1;
            code_idx = 7'(sv - SEL_INV_OFS);
        end
        if (code_idx == SEL_USER[6:0]) begin
            pat = i_user_code;
        end else if (code_ok) begin
            pat = {1'b0, CODE_TBL[code_idx]};
        end else begin
            pat = '0;
        end
        len24 = i_setup_word[LEN24_BIT];
        len   = len24 ? LEN24 : LEN23;
        mask  = len24 ? 24'hFFFFFF : 24'h7FFFFF;
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive bit timing, code match and turn-off tone scan
    logic          rx_s, rx_prev_r, edge_seen, bit_stb, dcs_rx_on, in_win;
    logic [CW-1:0] bit_cnt_r, bit_cnt_nxt, edge_cnt_r, edge_cnt_nxt;
    logic [23:0]   shreg_r, shreg_nxt, win;
    logic [4:0]    err_t, err_i, since_r, since_nxt, halves_r, halves_nxt;
    logic [1:0]    eval_cnt_r, eval_cnt_nxt;
    logic          hit, eval, recent, form_inv_r, form_inv_nxt, toff_det;
    logic          valid_r, valid_nxt, armed_r, armed_nxt, toff_seen_r, toff_seen_nxt;
    logic [7:0]    report_r, report_nxt;

    assign rx_s      = rx_sync_r[1];
    assign dcs_rx_on = i_dcs_en && !i_ctcss_en && !i_tx_mode;
    assign o_ctcss_det_en = i_ctcss_en && !i_dcs_en && !i_tx_mode;

    always_comb begin
        edge_seen    = rx_s ^ rx_prev_r;
        bit_stb      = !edge_seen && bit_cnt_r == BIT_MID;
        edge_cnt_nxt = edge_seen ? '0 : (edge_cnt_r == CNT_MAX ? edge_cnt_r : edge_cnt_r + 1'b1);
        bit_cnt_nxt  = (edge_seen || bit_cnt_r == BIT_LAST) ? '0 : bit_cnt_r + 1'b1;
        // oldest bit ends up at bit 0
        shreg_nxt    = bit_stb ? {rx_s, shreg_r[23:1]} : shreg_r;
        win          = len24 ? shreg_r : {1'b0, shreg_r[23:1]};
        err_t        = ones((win ^ pat) & mask);
        err_i        = ones((win ^ ~pat) & mask);
        hit          = code_ok && (err_t <= ERR_MAX || err_i <= ERR_MAX);
        since_nxt    = since_r;
        form_inv_nxt = form_inv_r;
        eval_cnt_nxt = eval_cnt_r;
        if (bit_stb) begin
            if (hit) begin
                since_nxt    = '0;
                form_inv_nxt = err_t > ERR_MAX;
            end else if (since_r != 5'h1F) begin
                since_nxt = since_r + 1'b1;
            end
            eval_cnt_nxt = eval_cnt_r + 1'b1;
        end
        eval   = dcs_rx_on && bit_stb && eval_cnt_r == EVAL_LAST;
        recent = since_nxt < len;
        in_win = edge_cnt_r >= TOFF_LO && edge_cnt_r <= TOFF_HI;
        halves_nxt = halves_r;
        if (edge_seen) begin
            halves_nxt = in_win ? halves_r + 1'b1 : '0;
        end
        toff_det = dcs_rx_on && armed_r && edge_seen && in_win && halves_r >= HALVES_LAST;
        if (toff_det) begin
            halves_nxt = '0;
        end
        valid_nxt     = valid_r;
        report_nxt    = report_r;
        armed_nxt     = armed_r || valid_r;
        toff_seen_nxt = toff_seen_r;
        if (eval) begin
            valid_nxt = recent;
            if (recent) begin
                report_nxt    = form_inv_nxt ? code_idx + SEL_INV_OFS : 8'(code_idx);
                toff_seen_nxt = 1'b0;
            end else begin
                report_nxt = toff_seen_r ? SEL_TOFF : 8'h00;
            end
        end
        if (toff_det) begin
            armed_nxt     = 1'b0;
            toff_seen_nxt = 1'b1;
            report_nxt    = SEL_TOFF;
        end
        if (!dcs_rx_on) begin
            valid_nxt     = 1'b0;
            armed_nxt     = 1'b0;
            toff_seen_nxt = 1'b0;
            eval_cnt_nxt  = '0;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_prev_r   <= 1'b0;
            bit_cnt_r   <= '0;
            edge_cnt_r  <= '0;
            shreg_r     <= '0;
            since_r     <= 5'h1F;
            form_inv_r  <= 1'b0;
            eval_cnt_r  <= '0;
            halves_r    <= '0;
            valid_r     <= 1'b0;
            report_r    <= 8'h00;
            armed_r     <= 1'b0;
            toff_seen_r <= 1'b0;
            o_dcs_event <= 1'b0;
        end else begin
            rx_prev_r   <= rx_s;
            bit_cnt_r   <= bit_cnt_nxt;
            edge_cnt_r  <= edge_cnt_nxt;
            shreg_r     <= shreg_nxt;
            since_r     <= since_nxt;
            form_inv_r  <= form_inv_nxt;
            eval_cnt_r  <= eval_cnt_nxt;
            halves_r    <= halves_nxt;
            valid_r     <= valid_nxt;
            report_r    <= report_nxt;
            armed_r     <= armed_nxt;
            toff_seen_r <= toff_seen_nxt;
            o_dcs_event <= toff_det;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // code encoder into the symbol buffer, tone lag and turn-off square
    logic          tx_on, enc_tick, pend_r, pend_nxt, push, buf_ready, toff_on;
    logic [CW-1:0] enc_cnt_r, enc_cnt_nxt, sq_cnt_r, sq_cnt_nxt;
    logic [4:0]    enc_idx_r, enc_idx_nxt;
    logic [11:0]   ph_cnt_r, ph_cnt_nxt;
    logic [7:0]    ph_r, ph_nxt, ph_tgt;
    logic          sq_r, sq_nxt;
    tx_sym_s       sym;

    always_comb begin
        tx_on        = i_tx_mode && i_dcs_en && code_ok;
        enc_tick     = enc_cnt_r == BIT_LAST;
        enc_cnt_nxt  = (enc_tick || !tx_on) ? '0 : enc_cnt_r + 1'b1;
        sym.code_bit  = pat[enc_idx_r];
        sym.shift_pos = sym.code_bit ^ code_inv;
        push         = tx_on && pend_r && buf_ready;
        // a full buffer holds the pending bit, stalling the encoder
        pend_nxt     = tx_on && ((pend_r && !buf_ready) || enc_tick);
        enc_idx_nxt  = enc_idx_r;
        if (!tx_on) begin
            enc_idx_nxt = '0;
        end else if (push) begin
            enc_idx_nxt = (enc_idx_r == len - 1'b1) ? '0 : enc_idx_r + 1'b1;
        end
        case (sel_r[PH_LSB+1:PH_LSB])
            2'b01:   ph_tgt = PH_120;
            2'b10:   ph_tgt = PH_180;
            2'b11:   ph_tgt = PH_240;
            default: ph_tgt = PH_0;
        endcase
        ph_cnt_nxt = (ph_cnt_r == PH_LAST) ? '0 : ph_cnt_r + 1'b1;
        ph_nxt     = (ph_cnt_r == PH_LAST && ph_r != ph_tgt) ? ph_r + 1'b1 : ph_r;
        toff_on    = i_tx_mode && sel_r[7:0] == SEL_TOFF;
        sq_cnt_nxt = (!toff_on || sq_cnt_r == TOFF_LAST) ? '0 : sq_cnt_r + 1'b1;
        sq_nxt     = toff_on && (sq_cnt_r == TOFF_LAST ? !sq_r : sq_r);
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            enc_cnt_r <= '0;
            enc_idx_r <= '0;
            pend_r    <= 1'b0;
            ph_cnt_r  <= '0;
            ph_r      <= PH_0;
            sq_cnt_r  <= '0;
            sq_r      <= 1'b0;
        end else begin
            enc_cnt_r <= enc_cnt_nxt;
            enc_idx_r <= enc_idx_nxt;
            pend_r    <= pend_nxt;
            ph_cnt_r  <= ph_cnt_nxt;
            ph_r      <= ph_nxt;
            sq_cnt_r  <= sq_cnt_nxt;
            sq_r      <= sq_nxt;
        end
    end

    tx_sym_buffer #(
        .WIDTH ($bits(tx_sym_s)),
        .DEPTH (2)
    ) u_buf (
        .i_clock      (i_clock),
        .i_rst_n      (rst_n),
        .i_push_valid (push),
        .i_push_data  (sym),
        .o_push_ready (buf_ready),
        .o_pop_valid  (o_tx_valid),
        .o_pop_data   (o_tx_sym),
        .i_pop_ready  (i_tx_ready)
    );

    assign o_tone_sel = sel_r[7:0];
    assign o_tone_lag = ph_r;
    assign o_toff_sq  = sq_r;

    ////////////////////////////////////////////////////////////////////////////
    // host register port
    logic [15:0] rd_data_nxt;

    always_comb begin
        sel_nxt     = (i_wr_en && i_addr == ADDR_SEL) ? i_wr_data : sel_r;
        rd_data_nxt = 16'h0000;
        case (i_addr)
            ADDR_STATUS: rd_data_nxt[ST_VALID_BIT] = valid_r;
            ADDR_REPORT: rd_data_nxt = {8'h00, report_r};
            default:     rd_data_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_r      <= SEL_RST;
            o_rd_data  <= 16'h0000;
            o_rd_valid <= 1'b0;
        end else begin
            sel_r      <= sel_nxt;
            o_rd_data  <= i_rd_en ? rd_data_nxt : 16'h0000;
            o_rd_valid <= i_rd_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_VALID_ON_EVAL: assert property (@(posedge i_clock) disable iff (!rst_n)
        $changed(valid_r) |-> ($past(eval) || !$past(dcs_rx_on)))
        else $error("valid changed outside an evaluation");
    AST_VALID_SET: assert property (@(posedge i_clock) disable iff (!rst_n)
        eval && recent |=> valid_r)
        else $error("valid not set after a match");
    AST_TOFF_REPORT: assert property (@(posedge i_clock) disable iff (!rst_n)
        toff_det |=> o_dcs_event && report_r == SEL_TOFF)
        else $error("turn-off tone not reported");
    AST_TOFF_ARMED: assert property (@(posedge i_clock) disable iff (!rst_n)
        $rose(armed_r) |-> $past(valid_r))
        else $error("turn-off scan without a valid code");
    AST_EXCLUSIVE: assert property (@(posedge i_clock) disable iff (!rst_n)
        o_ctcss_det_en |=> !valid_r && !armed_r)
        else $error("both sub-audio decoders active");
    AST_LAG_STEP: assert property (@(posedge i_clock) disable iff (!rst_n)
        $changed(ph_r) |-> ph_r == 8'($past(ph_r) + 1'b1) && $past(ph_cnt_r) == PH_LAST)
        else $error("tone lag stepped wrongly");
    AST_POLARITY: assert property (@(posedge i_clock) disable iff (!rst_n)
        push |-> sym.shift_pos == (sym.code_bit ^ (sel_r[7:0] > SEL_USER)))
        else $error("wrong shift polarity");
    AST_LSB_FIRST: assert property (@(posedge i_clock) disable iff (!rst_n)
        push && enc_idx_r == len - 1'b1 |=> enc_idx_r == 5'h00)
        else $error("code bit order broken");
    AST_REPORT_FORM: assert property (@(posedge i_clock) disable iff (!rst_n)
        eval && recent && form_inv_nxt && !toff_det |=> report_r == $past(code_idx) + SEL_INV_OFS)
        else $error("inverted form misreported");

endmodule

// *** verif/baseband_model.sv ***
`timescale 1ns/1ps
module baseband_model #(
    parameter int P_BIT  = 64,
    parameter int P_HALF = 32
) (
    input  wire logic                  i_clock,
    input  wire logic [1:0]            i_mode,
    input  wire logic [22:0]           i_code,
    input  wire logic                  i_tx_valid,
    input  wire subaudio_pkg::tx_sym_s i_tx_sym,
    output logic                       o_tx_ready,
    output logic                       o_rx_slice
);
    import subaudio_pkg::*;
    int      cnt = 0;
    int      pos = 0;
    int      n_rx = 0;
    tx_sym_s got [0:255];
    initial o_rx_slice = 1'b0;
    // modulator stalls half the time
    assign o_tx_ready = !cnt[3];
    always @(posedge i_clock) begin
        cnt <= cnt + 1;
        if (i_tx_valid && o_tx_ready && n_rx < 256) begin
            got[n_rx] <= i_tx_sym;
            n_rx <= n_rx + 1;
        end
        if (i_mode == 2'h2 && cnt >= P_HALF - 1) begin
            cnt <= 0;
            o_rx_slice <= !o_rx_slice;
        end else if (i_mode == 2'h1 && cnt >= P_BIT - 1) begin
            cnt <= 0;
            o_rx_slice <= i_code[pos];
            pos <= (pos == 22) ? 0 : pos + 1;
        end
    end
endmodule

// *** verif/tb_subaudio_digital_code_codec.sv ***
`timescale 1ns/1ps
module tb_subaudio_digital_code_codec;
    import subaudio_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdat = 16'h0000;
    logic        dcs_en = 1'b0;
    logic        ctcss_en = 1'b0;
    logic        tx_mode = 1'b0;
    logic [1:0]  fmode = 2'h0;
    logic [22:0] fcode = 23'h000000;
    logic [23:0] ucode = 24'h000000;
    logic        sq, prv;
    int          base, tog;
    logic [15:0] rdat;
    logic        rvld, slice, det, ev, tvld, trdy;
    logic [7:0]  tsel, tlag;
    tx_sym_s     tsym;
    int          seed = 26;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          idx, i;
    bit          hit;
    subaudio_digital_code_codec #(.P_BIT_CYC(64), .P_TOFF_HALF_CYC(32)) i_dut (
        .i_clock(clk), .i_arst_n(arst_n), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wr_data(wdat), .o_rd_data(rdat), .o_rd_valid(rvld),
        .i_setup_word(16'h0000), .i_user_code(ucode), .i_dcs_en(dcs_en),
        .i_ctcss_en(ctcss_en), .i_tx_mode(tx_mode), .i_rx_slice(slice),
        .o_ctcss_det_en(det), .o_dcs_event(ev), .o_tx_valid(tvld), .o_tx_sym(tsym),
        .i_tx_ready(trdy), .o_tone_sel(tsel), .o_tone_lag(tlag), .o_toff_sq(sq));
    baseband_model #(.P_BIT(64), .P_HALF(32)) i_far (
        .i_clock(clk), .i_mode(fmode), .i_code(fcode), .i_tx_valid(tvld),
        .i_tx_sym(tsym), .o_tx_ready(trdy), .o_rx_slice(slice));
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        addr = a;
        wdat = d;
        @(negedge clk);
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk);
        rd_en = 1'b1;
        addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        check("rd_valid", 16'h0001, {15'h0000, rvld});
        check("rd_data", e, rdat);
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        rd(ADDR_STATUS, 16'h0000);
        rd(ADDR_REPORT, 16'h0000);
        rd(8'h10, 16'h0000);
        idx = 1 + ($unsigned($random(seed)) % 83);
        ctcss_en = 1'b1;
        @(negedge clk);
        check("det_en", 16'h0001, {15'h0000, det});
        dcs_en = 1'b1;
        wr(ADDR_SEL, 16'(idx));
        check("det_en", 16'h0000, {15'h0000, det});
        check("tone_sel", 16'(idx), {8'h00, tsel});
        ctcss_en = 1'b0;
        tx_mode = 1'b1;
        repeat (1700) @(negedge clk);
        for (i = 0; i < 23; i++) begin
            check("code_bit", 16'(CODE_TBL[idx][i]), 16'(i_far.got[i].code_bit));
            check("shift", 16'(CODE_TBL[idx][i]), 16'(i_far.got[i].shift_pos));
        end
        wr(ADDR_SEL, 16'(idx) | 16'h0200);
        repeat (5000) @(negedge clk);
        check("lag", 16'h0001, 16'(tlag != 8'h00 && tlag < PH_180));
        tx_mode = 1'b0;
        fcode = CODE_TBL[idx] ^ 23'h000111;
        fmode = 2'h1;
        repeat (4500) @(negedge clk);
        rd(ADDR_STATUS, 16'h0400);
        rd(ADDR_REPORT, 16'(idx));
        fcode = ~CODE_TBL[idx];
        repeat (4500) @(negedge clk);
        rd(ADDR_REPORT, 16'(idx + 100));
        fmode = 2'h2;
        hit = 1'b0;
        for (i = 0; i < 3000 && !hit; i++) begin
            @(negedge clk);
            hit = (ev === 1'b1);
        end
        check("event", 16'h0001, 16'(hit));
        rd(ADDR_REPORT, 16'd254);
        fcode = CODE_TBL[idx] ^ 23'h001111;
        fmode = 2'h1;
        repeat (4500) @(negedge clk);
        rd(ADDR_STATUS, 16'h0000);
        fcode = CODE_TBL[idx];
        ucode = {1'b0, CODE_TBL[idx]};
        wr(ADDR_SEL, 16'h0054);
        repeat (4500) @(negedge clk);
        rd(ADDR_STATUS, 16'h0400);
        rd(ADDR_REPORT, 16'h0054);
        base = i_far.n_rx;
        wr(ADDR_SEL, 16'h00B8);
        tx_mode = 1'b1;
        repeat (1700) @(negedge clk);
        for (i = 0; i < 23; i++) begin
            check("user_bit", 16'(ucode[i]), 16'(i_far.got[base+i].code_bit));
            check("inv_shift", 16'(!ucode[i]), 16'(i_far.got[base+i].shift_pos));
        end
        wr(ADDR_SEL, 16'(SEL_TOFF));
        prv = sq;
        tog = 0;
        repeat (320) begin
            @(negedge clk);
            if (sq !== prv) begin
                tog++;
            end
            prv = sq;
        end
        check("toff_sq", 16'h000A, 16'(tog));
        dcs_en = 1'b0;
        wrap_up();
    end
endmodule
